// File: design/can_port_config_timeouts.sv
// Configuration, bit-rate selection and frame timeouts of one CAN port.
// Assumes the protocol engine reports the rate-switch phase, the bus
// state and the error counters, and owns the receive and send stores.
`include "cpct_defines.svh"

module can_port_config_timeouts
   import cpct_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `CPCT_MS_CYCLES,
   parameter int unsigned TQ_CLK_HZ = `CPCT_TQ_CLK_HZ
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Port start and stop
   input wire logic start_i,
   input wire logic stop_i,
   output logic running_o,
   // Configuration, taken only while stopped
   input wire logic cfg_wr_i,
   input wire logic [1:0] cfg_mode_i,
   input wire logic [4:0] cfg_nom_idx_i,
   input wire logic cfg_nom_cust_i,
   input wire logic [9:0] cfg_nom_brp_i,
   input wire logic [7:0] cfg_nom_tseg1_i,
   input wire logic [6:0] cfg_nom_tseg2_i,
   input wire logic [3:0] cfg_dat_idx_i,
   input wire logic cfg_dat_cust_i,
   input wire logic [9:0] cfg_dat_brp_i,
   input wire logic [7:0] cfg_dat_tseg1_i,
   input wire logic [6:0] cfg_dat_tseg2_i,
   input wire logic [31:0] cfg_rx_tmo_i,
   input wire logic [31:0] cfg_tx_tmo_i,
   input wire logic cfg_listen_i,
   input wire logic cfg_sshot_i,
   output logic cfg_reject_o,
   output logic [1:0] mode_o,
   output logic listen_only_o,
   output logic single_shot_o,
   // Enables that may change at any time
   input wire logic en_wr_i,
   input wire logic en_log_bus_i,
   input wire logic en_log_xcvr_i,
   input wire logic en_self_rx_i,
   output logic log_bus_o,
   output logic log_xcvr_o,
   output logic self_rx_o,
   // Bit timing towards the protocol engine
   input wire logic brs_phase_i,
   output logic fast_phase_o,
   output logic [9:0] bit_brp_o,
   output logic [7:0] bit_tseg1_o,
   output logic [6:0] bit_tseg2_o,
   // Bus state and error counters
   input wire logic [1:0] comm_state_i,
   input wire logic [7:0] rec_i,
   input wire logic [7:0] tec_i,
   output logic [1:0] comm_state_o,
   output logic [7:0] rec_o,
   output logic [7:0] tec_o,
   // Frame read
   input wire logic rd_req_i,
   input wire logic rx_avail_i,
   output logic rd_done_o,
   output logic rd_err_o,
   output logic rx_pop_o,
   // Frame write
   input wire logic wr_req_i,
   input wire logic tx_free_i,
   output logic wr_done_o,
   output logic wr_err_o,
   output logic tx_push_o
);
   localparam cpct_top_s ST_RST = '{
      mode: CPCT_MODE_CLASSIC,
      nom_idx: `CPCT_NOM_IDX_RST,
      dat_idx: `CPCT_DAT_IDX_RST,
      rx_tmo: `CPCT_TMO_RST,
      tx_tmo: `CPCT_TMO_RST,
      ts1: `CPCT_TSEG1_TQ,
      ts2: `CPCT_TSEG2_TQ,
      default: '0};

   cpct_top_s st_q;
   cpct_top_s st_d;
   cpct_brp_t nom_brp_p;
   cpct_brp_t dat_brp_p;
   logic rd_done;
   logic rd_err;
   logic rx_pop;
   logic wr_done;
   logic wr_err;
   logic tx_push;

   cpct_bit_timing #(
      .TQ_CLK_HZ(TQ_CLK_HZ)
   ) u_timing (
      .nom_idx_i(st_q.nom_idx),
      .dat_idx_i(st_q.dat_idx),
      .nom_brp_o(nom_brp_p),
      .dat_brp_o(dat_brp_p)
   );

   // A stopped port fails any pending or new wait at once, so a reader
   // or writer never hangs on a port that cannot move frames.
   cpct_timeout_wait #(
      .MS_CYCLES(MS_CYCLES)
   ) u_rx_wait (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .req_i(rd_req_i),
      .timeout_i(st_q.rx_tmo),
      .ready_i(rx_avail_i),
      .abort_i(!st_q.running),
      .done_o(rd_done),
      .err_o(rd_err),
      .take_o(rx_pop)
   );

   cpct_timeout_wait #(
      .MS_CYCLES(MS_CYCLES)
   ) u_tx_wait (
      .ref_clk_i(ref_clk_i),
      .rstn_i(rstn_i),
      .req_i(wr_req_i),
      .timeout_i(st_q.tx_tmo),
      .ready_i(tx_free_i),
      .abort_i(!st_q.running),
      .done_o(wr_done),
      .err_o(wr_err),
      .take_o(tx_push)
   );

   always_comb
   begin
      logic cfg_ok;
      cfg_ok = 1'b0;
      st_d = st_q;
      st_d.reject = 1'b0;
      st_d.comm = comm_state_i;
      st_d.rec = rec_i;
      st_d.tec = tec_i;
      if (stop_i)
         st_d.running = 1'b0;
      else if (start_i)
         st_d.running = 1'b1;
      if (en_wr_i)
      begin
         st_d.log_bus = en_log_bus_i;
         st_d.log_xcvr = en_log_xcvr_i;
         st_d.self_rx = en_self_rx_i;
      end
      // A write with an unknown mode or a preset index off the table
      // is refused whole rather than half applied.
      cfg_ok = (cfg_mode_i != 2'b11) &&
         (cfg_nom_cust_i || cfg_nom_idx_i < 5'(`CPCT_NOM_RATES)) &&
         (cfg_dat_cust_i || cfg_dat_idx_i < 4'(`CPCT_DAT_RATES));
      if (cfg_wr_i && (st_q.running || !cfg_ok))
         st_d.reject = 1'b1;
      else if (cfg_wr_i)
      begin
         st_d.mode = cpct_mode_e'(cfg_mode_i);
         st_d.nom_cust = cfg_nom_cust_i;
         st_d.dat_cust = cfg_dat_cust_i;
         st_d.nom_brp_c = cfg_nom_brp_i;
         st_d.nom_ts1_c = cfg_nom_tseg1_i;
         st_d.nom_ts2_c = cfg_nom_tseg2_i;
         st_d.dat_brp_c = cfg_dat_brp_i;
         st_d.dat_ts1_c = cfg_dat_tseg1_i;
         st_d.dat_ts2_c = cfg_dat_tseg2_i;
         if (!cfg_nom_cust_i)
            st_d.nom_idx = cfg_nom_idx_i;
         if (!cfg_dat_cust_i)
            st_d.dat_idx = cfg_dat_idx_i;
         st_d.rx_tmo = cfg_rx_tmo_i;
         st_d.tx_tmo = cfg_tx_tmo_i;
         st_d.listen = cfg_listen_i;
         st_d.sshot = cfg_sshot_i;
      end
      st_d.fast = (st_q.mode == CPCT_MODE_FD_BRS) && brs_phase_i;
      if (st_d.fast)
      begin
         st_d.brp = st_q.dat_cust ? st_q.dat_brp_c : dat_brp_p;
         st_d.ts1 = st_q.dat_cust ? st_q.dat_ts1_c : `CPCT_TSEG1_TQ;
         st_d.ts2 = st_q.dat_cust ? st_q.dat_ts2_c : `CPCT_TSEG2_TQ;
      end
      else
      begin
         st_d.brp = st_q.nom_cust ? st_q.nom_brp_c : nom_brp_p;
         st_d.ts1 = st_q.nom_cust ? st_q.nom_ts1_c : `CPCT_TSEG1_TQ;
         st_d.ts2 = st_q.nom_cust ? st_q.nom_ts2_c : `CPCT_TSEG2_TQ;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_q <= ST_RST;
      else
         st_q <= st_d;
   end

   assign running_o = st_q.running;
   assign cfg_reject_o = st_q.reject;
   assign mode_o = st_q.mode;
   assign listen_only_o = st_q.listen;
   assign single_shot_o = st_q.sshot;
   assign log_bus_o = st_q.log_bus;
   assign log_xcvr_o = st_q.log_xcvr;
   assign self_rx_o = st_q.self_rx;
   assign fast_phase_o = st_q.fast;
   assign bit_brp_o = st_q.brp;
   assign bit_tseg1_o = st_q.ts1;
   assign bit_tseg2_o = st_q.ts2;
   assign comm_state_o = st_q.comm;
   assign rec_o = st_q.rec;
   assign tec_o = st_q.tec;
   assign rd_done_o = rd_done;
   assign rd_err_o = rd_err;
   assign rx_pop_o = rx_pop;
   assign wr_done_o = wr_done;
   assign wr_err_o = wr_err;
   assign tx_push_o = tx_push;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);

   sequence cfg_while_running;
      st_q.running && cfg_wr_i;
   endsequence
   sequence cfg_left_alone;
      cfg_reject_o && $stable(st_q.mode) && $stable(st_q.rx_tmo) &&
         $stable(st_q.tx_tmo) && $stable(st_q.nom_idx) &&
         $stable(st_q.listen);
   endsequence

   cfg_lock_a: assert property (
      cfg_while_running |=> cfg_left_alone)
      else $error("configuration changed while running");
   live_enable_a: assert property (
      en_wr_i |=> (self_rx_o == $past(en_self_rx_i) &&
         log_bus_o == $past(en_log_bus_i)))
      else $error("live enable not taken");
   nominal_only_a: assert property (
      (st_q.mode != CPCT_MODE_FD_BRS) |=> !fast_phase_o)
      else $error("data-phase timing outside switching mode");
   data_phase_a: assert property (
      fast_phase_o |-> ($past(brs_phase_i) &&
         $past(st_q.mode) == CPCT_MODE_FD_BRS))
      else $error("data-phase timing without rate switch");
   reset_default_a: assert property (
      $rose(rstn_i) |-> (st_q.nom_idx == `CPCT_NOM_IDX_RST &&
         st_q.dat_idx == `CPCT_DAT_IDX_RST &&
         st_q.mode == CPCT_MODE_CLASSIC &&
         st_q.rx_tmo == `CPCT_TMO_RST && st_q.tx_tmo == `CPCT_TMO_RST))
      else $error("wrong defaults after reset");
   preset_point_a: assert property (
      (!fast_phase_o && !$past(st_q.nom_cust)) |->
         (bit_tseg1_o == `CPCT_TSEG1_TQ && bit_tseg2_o == `CPCT_TSEG2_TQ))
      else $error("preset sample point not 87.5 percent");
   custom_field_a: assert property (
      (!fast_phase_o && $past(st_q.nom_cust)) |->
         (bit_brp_o == $past(st_q.nom_brp_c) &&
          bit_tseg1_o == $past(st_q.nom_ts1_c)))
      else $error("custom timing fields not applied");
   index_range_a: assert property (
      st_q.nom_idx < 5'(`CPCT_NOM_RATES) &&
         st_q.dat_idx < 4'(`CPCT_DAT_RATES))
      else $error("preset rate index off the table");
endmodule // can_port_config_timeouts

// File: design/cpct_bit_timing.sv
// Preset rate tables: prescaler for each nominal and data-phase rate.
// Assumes the indices are kept in range by the instantiating module.
`include "cpct_defines.svh"
module cpct_bit_timing
   import cpct_pkg::*;
#(
   parameter int unsigned TQ_CLK_HZ = `CPCT_TQ_CLK_HZ
)
(
   // Rate selection
   input wire logic [4:0] nom_idx_i,
   input wire logic [3:0] dat_idx_i,
   // Prescalers
   output cpct_brp_t nom_brp_o,
   output cpct_brp_t dat_brp_o
);
   localparam int unsigned NOM_BPS [0:`CPCT_NOM_RATES-1] = '{
      5000, 6150, 10000, 12500, 16000, 20000, 25000, 31250, 33330,
      40000, 50000, 62500, 80000, 83330, 100000, 125000, 160000,
      200000, 250000, 400000, 500000, 800000, 1000000};
   localparam int unsigned DAT_BPS [0:`CPCT_DAT_RATES-1] = '{
      200000, 250000, 400000, 500000, 800000, 1000000, 1250000,
      1600000, 2000000, 2500000, 4000000, 5000000};
   localparam int unsigned TQB = `CPCT_TQ_PER_BIT;
   cpct_brp_t nom_tab [0:`CPCT_NOM_RATES-1];
   cpct_brp_t dat_tab [0:`CPCT_DAT_RATES-1];
   // Prescalers are rounded to nearest; rates that do not divide the
   // quantum clock evenly come out slightly off their nominal value.
   for (genvar g = 0; g < `CPCT_NOM_RATES; g++)
   begin : g_nom
      assign nom_tab[g] = cpct_brp_t'((TQ_CLK_HZ + NOM_BPS[g] * TQB / 2)
         / (NOM_BPS[g] * TQB));
   end
   for (genvar g = 0; g < `CPCT_DAT_RATES; g++)
   begin : g_dat
      assign dat_tab[g] = cpct_brp_t'((TQ_CLK_HZ + DAT_BPS[g] * TQB / 2)
         / (DAT_BPS[g] * TQB));
   end
   assign nom_brp_o = nom_tab[nom_idx_i];
   assign dat_brp_o = dat_tab[dat_idx_i];
endmodule // cpct_bit_timing

// File: design/cpct_defines.svh
// Constants for the CAN port configuration and timeout block.
// Assumes inclusion by bare name from the design files.
`ifndef CPCT_DEFINES_SVH
`define CPCT_DEFINES_SVH
`define CPCT_NOM_RATES 23
`define CPCT_DAT_RATES 12
// Index of 500 kb/s in the nominal and in the data-phase rate tables.
`define CPCT_NOM_IDX_RST 5'h14
`define CPCT_DAT_IDX_RST 4'h3
// Sixteen quanta per bit, sample after 1 + 13 quanta: 87.5 percent.
`define CPCT_TQ_PER_BIT 16
`define CPCT_TSEG1_TQ 8'h0d
`define CPCT_TSEG2_TQ 7'h02
// Clock that the protocol engine counts quanta on.
`define CPCT_TQ_CLK_HZ 80000000
`define CPCT_TMO_RST 32'h00002710
`define CPCT_TMO_NOWAIT 32'h00000000
`define CPCT_TMO_FOREVER 32'hffffffff
`define CPCT_MS_NS 1000000
`define CPCT_CLK_NS 50
`define CPCT_MS_CYCLES (`CPCT_MS_NS / `CPCT_CLK_NS)
`endif

// File: design/cpct_pkg.sv
// Types shared by the CAN port configuration and timeout block.
// Assumes nothing of its surroundings.
package cpct_pkg;
   typedef enum logic [1:0] {
      CPCT_MODE_CLASSIC = 2'b00,
      CPCT_MODE_FD = 2'b01,
      CPCT_MODE_FD_BRS = 2'b10
   } cpct_mode_e;
   typedef enum logic {
      CPCT_W_IDLE = 1'b0,
      CPCT_W_WAIT = 1'b1
   } cpct_wait_e;
   typedef logic [9:0] cpct_brp_t;
   typedef logic [7:0] cpct_ts1_t;
   typedef logic [6:0] cpct_ts2_t;
   typedef struct packed {
      cpct_wait_e state;
      logic endless;
      logic [31:0] remain;
      logic [31:0] ms_cnt;
      logic done;
      logic err;
      logic take;
   } cpct_wait_s;
   typedef struct packed {
      logic running;
      cpct_mode_e mode;
      logic [4:0] nom_idx;
      logic [3:0] dat_idx;
      logic nom_cust;
      logic dat_cust;
      cpct_brp_t nom_brp_c;
      cpct_ts1_t nom_ts1_c;
      cpct_ts2_t nom_ts2_c;
      cpct_brp_t dat_brp_c;
      cpct_ts1_t dat_ts1_c;
      cpct_ts2_t dat_ts2_c;
      logic [31:0] rx_tmo;
      logic [31:0] tx_tmo;
      logic listen;
      logic sshot;
      logic log_bus;
      logic log_xcvr;
      logic self_rx;
      logic reject;
      logic fast;
      cpct_brp_t brp;
      cpct_ts1_t ts1;
      cpct_ts2_t ts2;
      logic [1:0] comm;
      logic [7:0] rec;
      logic [7:0] tec;
   } cpct_top_s;
endpackage : cpct_pkg

// File: design/cpct_timeout_wait.sv
// Blocking, polling or endless wait for a frame or a free buffer.
// Assumes ready_i drops within a cycle of take_o.
`include "cpct_defines.svh"
module cpct_timeout_wait
   import cpct_pkg::*;
#(
   parameter int unsigned MS_CYCLES = `CPCT_MS_CYCLES
)
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Request
   input wire logic req_i,
   input wire logic [31:0] timeout_i,
   input wire logic ready_i,
   input wire logic abort_i,
   // Answer
   output logic done_o,
   output logic err_o,
   output logic take_o
);
   localparam cpct_wait_s ST_RST = '{state: CPCT_W_IDLE, default: '0};
   cpct_wait_s st_q;
   cpct_wait_s st_d;

   always_comb
   begin
      st_d = st_q;
      st_d.done = 1'b0;
      st_d.err = 1'b0;
      st_d.take = 1'b0;
      case (st_q.state)
         CPCT_W_IDLE:
         begin
            if (req_i && abort_i)
            begin
               st_d.done = 1'b1;
               st_d.err = 1'b1;
            end
            else if (req_i && ready_i)
            begin
               st_d.done = 1'b1;
               st_d.take = 1'b1;
            end
            else if (req_i && timeout_i == `CPCT_TMO_NOWAIT)
            begin
               st_d.done = 1'b1;
               st_d.err = 1'b1;
            end
            else if (req_i)
            begin
               // Any negative count waits without limit, not only -1.
               st_d.state = CPCT_W_WAIT;
               st_d.endless = timeout_i[31];
               st_d.remain = timeout_i;
               st_d.ms_cnt = '0;
            end
         end
         CPCT_W_WAIT:
         begin
            if (abort_i || ready_i)
            begin
               st_d.state = CPCT_W_IDLE;
               st_d.done = 1'b1;
               st_d.err = abort_i;
               st_d.take = !abort_i;
            end
            else if (st_q.ms_cnt == 32'(MS_CYCLES - 1))
            begin
               st_d.ms_cnt = '0;
               if (!st_q.endless && st_q.remain == 32'h00000001)
               begin
                  st_d.state = CPCT_W_IDLE;
                  st_d.done = 1'b1;
                  st_d.err = 1'b1;
               end
               else if (!st_q.endless)
               begin
                  st_d.remain = st_q.remain - 32'h00000001;
               end
            end
            else
            begin
               st_d.ms_cnt = st_q.ms_cnt + 32'h00000001;
            end
         end
         default: st_d = ST_RST;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         st_q <= ST_RST;
      else
         st_q <= st_d;
   end

   assign done_o = st_q.done;
   assign err_o = st_q.err;
   assign take_o = st_q.take;

   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rstn_i);
   zero_wait_a: assert property (
      (st_q.state == CPCT_W_IDLE && req_i && !abort_i && !ready_i &&
       timeout_i == `CPCT_TMO_NOWAIT) |=> (done_o && err_o && !take_o))
      else $error("zero timeout did not fail at once");
   ready_take_a: assert property (
      (st_q.state == CPCT_W_IDLE && req_i && !abort_i && ready_i)
      |=> (done_o && take_o && !err_o))
      else $error("ready request not served next cycle");
   endless_wait_a: assert property (
      (st_q.state == CPCT_W_WAIT && st_q.endless && !abort_i)
      |=> !err_o)
      else $error("endless wait timed out");
endmodule // cpct_timeout_wait

// File: tb/can_port_config_timeouts_bench.sv
// Self-checking bench for the CAN port configuration and timeout block.
// Assumes a 20 MHz clock and a shortened millisecond of four cycles.
`include "cpct_defines.svh"
module can_port_config_timeouts_bench
   import cpct_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   localparam int unsigned MS = 4;
   logic ref_clk_i, rstn_i, start_i, stop_i, cfg_wr_i, cfg_nom_cust_i;
   logic cfg_dat_cust_i, cfg_listen_i, cfg_sshot_i, en_wr_i, brs_phase_i;
   logic en_log_bus_i, en_log_xcvr_i, en_self_rx_i, rd_req_i, wr_req_i;
   logic rx_put, rx_avail, tx_free, running_o, cfg_reject_o, listen_only_o;
   logic single_shot_o, log_bus_o, log_xcvr_o, self_rx_o, fast_phase_o;
   logic rd_done_o, rd_err_o, rx_pop_o, wr_done_o, wr_err_o, tx_push_o;
   logic [1:0] cfg_mode_i, mode_o, comm_state_i, comm_state_o;
   logic [4:0] cfg_nom_idx_i;
   logic [3:0] cfg_dat_idx_i;
   logic [7:0] rec_i, tec_i, rec_o, tec_o, tx_delay, bit_tseg1_o;
   logic [6:0] bit_tseg2_o;
   logic [9:0] bit_brp_o, nom_brp;
   logic [31:0] cfg_rx_tmo_i, cfg_tx_tmo_i;
   logic err, pp, rej;
   int n_errors, n_tests, lat;
   real nom_kb [23] = '{5.0, 6.15, 10.0, 12.5, 16.0, 20.0, 25.0, 31.25,
      33.33, 40.0, 50.0, 62.5, 80.0, 83.33, 100.0, 125.0, 160.0, 200.0,
      250.0, 400.0, 500.0, 800.0, 1000.0};
   real dat_kb [12] = '{200.0, 250.0, 400.0, 500.0, 800.0, 1000.0, 1250.0,
      1600.0, 2000.0, 2500.0, 4000.0, 5000.0};

   can_port_config_timeouts #(.MS_CYCLES(MS)) can_port_config_timeouts_inst
   (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .start_i(start_i),
      .stop_i(stop_i), .running_o(running_o), .cfg_wr_i(cfg_wr_i),
      .cfg_mode_i(cfg_mode_i), .cfg_nom_idx_i(cfg_nom_idx_i),
      .cfg_nom_cust_i(cfg_nom_cust_i), .cfg_nom_brp_i(nom_brp),
      .cfg_nom_tseg1_i(8'h14), .cfg_nom_tseg2_i(7'h05),
      .cfg_dat_idx_i(cfg_dat_idx_i), .cfg_dat_cust_i(cfg_dat_cust_i),
      .cfg_dat_brp_i(10'h003), .cfg_dat_tseg1_i(8'h09),
      .cfg_dat_tseg2_i(7'h04), .cfg_rx_tmo_i(cfg_rx_tmo_i),
      .cfg_tx_tmo_i(cfg_tx_tmo_i), .cfg_listen_i(cfg_listen_i),
      .cfg_sshot_i(cfg_sshot_i), .cfg_reject_o(cfg_reject_o),
      .mode_o(mode_o), .listen_only_o(listen_only_o),
      .single_shot_o(single_shot_o), .en_wr_i(en_wr_i),
      .en_log_bus_i(en_log_bus_i), .en_log_xcvr_i(en_log_xcvr_i),
      .en_self_rx_i(en_self_rx_i), .log_bus_o(log_bus_o),
      .log_xcvr_o(log_xcvr_o), .self_rx_o(self_rx_o),
      .brs_phase_i(brs_phase_i), .fast_phase_o(fast_phase_o),
      .bit_brp_o(bit_brp_o), .bit_tseg1_o(bit_tseg1_o),
      .bit_tseg2_o(bit_tseg2_o), .comm_state_i(comm_state_i),
      .rec_i(rec_i), .tec_i(tec_i), .comm_state_o(comm_state_o),
      .rec_o(rec_o), .tec_o(tec_o), .rd_req_i(rd_req_i),
      .rx_avail_i(rx_avail), .rd_done_o(rd_done_o), .rd_err_o(rd_err_o),
      .rx_pop_o(rx_pop_o), .wr_req_i(wr_req_i), .tx_free_i(tx_free),
      .wr_done_o(wr_done_o), .wr_err_o(wr_err_o), .tx_push_o(tx_push_o)
   );

   cpct_bus_model cpct_bus_model_inst
   (
      .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .rx_put_i(rx_put),
      .tx_delay_i(tx_delay), .rx_pop_i(rx_pop_o), .tx_push_i(tx_push_o),
      .rx_avail_o(rx_avail), .tx_free_o(tx_free)
   );

   initial
   begin
      ref_clk_i = 1'b0;
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   task automatic end_sim();
      if (n_errors == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Preset prescaler for a rate in kb/s, rounded to the nearest whole clock cycle per quantum.
   function automatic logic [31:0] brp_of(input real kb);
      return 32'($rtoi(real'(`CPCT_TQ_CLK_HZ) / (kb * 16000.0) + 0.5));
   endfunction

   task automatic run(input logic go);
      @(negedge ref_clk_i);
      start_i = go;
      stop_i = !go;
      @(negedge ref_clk_i);
      start_i = 1'b0;
      stop_i = 1'b0;
      @(negedge ref_clk_i);
   endtask

   // One configuration write; bit timing has settled on return.
   task automatic cfg(input logic [1:0] m, input logic [4:0] ni,
      input logic [3:0] di, input logic [31:0] rx, input logic [31:0] tx,
      output logic rj);
      @(negedge ref_clk_i);
      cfg_mode_i = m;
      cfg_nom_idx_i = ni;
      cfg_dat_idx_i = di;
      cfg_rx_tmo_i = rx;
      cfg_tx_tmo_i = tx;
      cfg_wr_i = 1'b1;
      @(negedge ref_clk_i);
      cfg_wr_i = 1'b0;
      rj = cfg_reject_o;
      @(negedge ref_clk_i);
   endtask

   // Frame read or write; lat counts cycles from the taking edge to done.
   task automatic acc(input logic wr, output int lt, output logic er,
      output logic pu);
      @(negedge ref_clk_i);
      if (wr)
         wr_req_i = 1'b1;
      else
         rd_req_i = 1'b1;
      @(negedge ref_clk_i);
      wr_req_i = 1'b0;
      rd_req_i = 1'b0;
      lt = 1;
      while ((wr ? wr_done_o : rd_done_o) !== 1'b1)
      begin
         if (lt > 50000)
         begin
            n_errors++;
            end_sim();
         end
         @(negedge ref_clk_i);
         lt++;
      end
      er = wr ? wr_err_o : rd_err_o;
      pu = wr ? tx_push_o : rx_pop_o;
      @(negedge ref_clk_i);
   endtask

   initial
   begin
      {rstn_i, start_i, stop_i, cfg_wr_i, cfg_nom_cust_i, cfg_dat_cust_i} = '0;
      {cfg_listen_i, cfg_sshot_i, en_wr_i, brs_phase_i, en_log_bus_i} = '0;
      {en_log_xcvr_i, en_self_rx_i, rd_req_i, wr_req_i, rx_put} = '0;
      {cfg_mode_i, comm_state_i, cfg_nom_idx_i, cfg_dat_idx_i} = '0;
      {rec_i, tec_i, tx_delay, cfg_rx_tmo_i, cfg_tx_tmo_i} = '0;
      nom_brp = 10'h007;
      n_errors = 0;
      n_tests = 0;
      repeat (8) @(negedge ref_clk_i);
      rstn_i = 1'b1;
      repeat (2) @(negedge ref_clk_i);
      chk({running_o, mode_o, listen_only_o, single_shot_o}, 32'h0);
      chk({log_bus_o, log_xcvr_o, self_rx_o, fast_phase_o}, 32'h0);
      chk(bit_brp_o, brp_of(500.0));
      chk({bit_tseg1_o, bit_tseg2_o}, {8'h0d, 7'h02});
      acc(1'b0, lat, err, pp);
      chk({lat, err, pp}, {32'h1, 2'b10});
      run(1'b1);
      acc(1'b0, lat, err, pp);
      chk({lat, err}, {32'(10000 * MS + 1), 1'b1});
      comm_state_i = 2'h2;
      rec_i = 8'h5a;
      tec_i = 8'ha5;
      cfg(2'h1, 5'h00, 4'h0, 32'h0, 32'h0, rej);
      chk({rej, mode_o, comm_state_o, rec_o, tec_o}, 32'h12_5aa5);
      en_log_bus_i = 1'b1;
      en_self_rx_i = 1'b1;
      en_wr_i = 1'b1;
      @(negedge ref_clk_i);
      en_wr_i = 1'b0;
      chk({log_bus_o, log_xcvr_o, self_rx_o}, 32'h5);
      run(1'b0);
      for (int i = 0; i < 23; i++)
      begin
         cfg(2'h0, 5'(i), 4'h3, 32'h0, 32'h0, rej);
         chk({rej, mode_o, bit_brp_o}, brp_of(nom_kb[i]));
      end
      cfg_listen_i = 1'b1;
      cfg_sshot_i = 1'b1;
      brs_phase_i = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
         cfg(2'h2, 5'h14, 4'(i), 32'h0, 32'h0, rej);
         chk({rej, fast_phase_o, bit_brp_o}, 32'h400 | brp_of(dat_kb[i]));
      end
      chk({listen_only_o, single_shot_o, bit_tseg1_o}, 32'h30d);
      brs_phase_i = 1'b0;
      @(negedge ref_clk_i);
      chk({fast_phase_o, bit_brp_o}, brp_of(500.0));
      brs_phase_i = 1'b1;
      cfg(2'h1, 5'h14, 4'h0, 32'h0, 32'h0, rej);
      chk({fast_phase_o, bit_brp_o}, brp_of(500.0));
      cfg(2'h3, 5'h14, 4'h0, 32'h0, 32'h0, rej);
      chk({rej, mode_o}, 32'h5);
      cfg(2'h0, 5'h17, 4'h0, 32'h0, 32'h0, rej);
      chk({rej, mode_o}, 32'h5);
      cfg(2'h2, 5'h14, 4'hc, 32'h0, 32'h0, rej);
      chk({rej, mode_o}, 32'h5);
      cfg_nom_cust_i = 1'b1;
      cfg_dat_cust_i = 1'b1;
      cfg(2'h2, 5'h1f, 4'hf, 32'h0, 32'h0, rej);
      chk({rej, bit_brp_o, bit_tseg1_o, bit_tseg2_o}, {7'h0, 10'h3, 8'h9, 7'h4});
      brs_phase_i = 1'b0;
      @(negedge ref_clk_i);
      chk({bit_brp_o, bit_tseg1_o, bit_tseg2_o}, {10'h7, 8'h14, 7'h5});
      cfg(2'h0, 5'h14, 4'h3, 32'h2, 32'h0, rej);
      run(1'b1);
      acc(1'b0, lat, err, pp);
      chk({lat, err, pp}, {32'(2 * MS + 1), 2'b10});
      rx_put = 1'b1;
      @(negedge ref_clk_i);
      rx_put = 1'b0;
      acc(1'b0, lat, err, pp);
      chk({lat, err, pp}, {32'h1, 2'b01});
      tx_delay = 8'h05;
      acc(1'b1, lat, err, pp);
      chk({lat, err, pp}, {32'h1, 2'b01});
      acc(1'b1, lat, err, pp);
      chk({lat, err, pp}, {32'h1, 2'b10});
      run(1'b0);
      cfg(2'h0, 5'h14, 4'h3, 32'hffffffff, 32'h3, rej);
      run(1'b1);
      tx_delay = 8'h28;
      acc(1'b1, lat, err, pp);
      acc(1'b1, lat, err, pp);
      chk({lat, err}, {32'(3 * MS + 1), 1'b1});
      repeat (40) @(negedge ref_clk_i);
      tx_delay = 8'h05;
      acc(1'b1, lat, err, pp);
      chk({lat, err, pp}, {32'h1, 2'b01});
      acc(1'b1, lat, err, pp);
      acc(1'b1, lat, err, pp);
      chk({lat < 13, err, pp}, 32'h5);
      fork
         acc(1'b0, lat, err, pp);
         begin
            repeat (30) @(negedge ref_clk_i);
            rx_put = 1'b1;
            @(negedge ref_clk_i);
            rx_put = 1'b0;
         end
      join
      chk({lat > 30, err, pp}, 32'h5);
      end_sim();
   end
endmodule // can_port_config_timeouts_bench

// File: tb/cpct_bus_model.sv
// Far side of the port: protocol engine with a two-frame receive store
// and one send element. Assumes pop and push pulses last one cycle.
module cpct_bus_model
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rstn_i,
   // Commands from the bench
   input wire logic rx_put_i,
   input wire logic [7:0] tx_delay_i,
   // Frame store side
   input wire logic rx_pop_i,
   input wire logic tx_push_i,
   output logic rx_avail_o,
   output logic tx_free_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] rx_cnt_q;
   logic [7:0] tx_left_q;
   always_ff @(posedge ref_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rx_cnt_q <= 2'h0;
         tx_left_q <= 8'h00;
      end
      else
      begin
         // The store holds two frames; a third arrival is lost.
         if (rx_put_i && !rx_pop_i && rx_cnt_q != 2'h2)
            rx_cnt_q <= rx_cnt_q + 2'h1;
         else if (rx_pop_i && !rx_put_i && rx_cnt_q != 2'h0)
            rx_cnt_q <= rx_cnt_q - 2'h1;
         // The element frees only once its frame has gone out whole.
         if (tx_push_i)
            tx_left_q <= tx_delay_i;
         else if (tx_left_q != 8'h00)
            tx_left_q <= tx_left_q - 8'h01;
      end
   end
   assign rx_avail_o = (rx_cnt_q != 2'h0);
   assign tx_free_o = (tx_left_q == 8'h00);
endmodule // cpct_bus_model
